// [core/set_file_pkg.sv]
// Package with constants and carrier types for the set-file-all-ones execution unit.
package set_file_pkg;

    // ------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------
    localparam logic [6:0]  SET_FILE_OPCODE      = 7'h34;
    localparam int          OPCODE_MSB           = 15;
    localparam int          OPCODE_LSB           = 9;
    localparam int          ACCESS_BIT_POS       = 8;
    localparam logic [7:0]  SET_FILE_VALUE       = 8'hff;
    localparam logic [7:0]  INDEXED_LIMIT        = 8'h5f;

    // ------------------------------------------------------------
    // Access bank layout
    // ------------------------------------------------------------
    localparam logic [7:0]  ACCESS_SPLIT         = 8'h80;
    localparam logic [3:0]  ACCESS_LOW_BANK      = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH_BANK     = 4'hf;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_WORD           = 16'h0000;
    localparam logic [11:0] RESET_ADDR           = 12'h000;

    typedef enum logic [3:0]
    {
        PHASE_DECODE  = 4'b0001,
        PHASE_READ    = 4'b0010,
        PHASE_PROCESS = 4'b0100,
        PHASE_WRITE   = 4'b1000
    } phase_type;

    typedef struct packed
    {
        logic        valid;
        logic [11:0] addr;
        logic [7:0]  data;
    } mem_access_type;

    typedef struct packed
    {
        logic        valid;
        logic        indexed;
        logic [11:0] addr;
    } target_type;

endpackage : set_file_pkg

// [core/set_file_addr_resolve.sv]
// Operand address resolver: access bank, banked or indexed literal offset.
`timescale 1ns/1ps
`default_nettype none
module set_file_addr_resolve
    import set_file_pkg::*;
(
    input  wire logic       i_access_bit,
    input  wire logic [7:0] i_file_addr,
    input  wire logic [3:0] i_bank_select_register,
    input  wire logic       i_ext_enable,
    input  wire logic [11:0] i_index_base,
    output logic            o_indexed,
    output logic [11:0]     o_addr
);
    import set_file_pkg::*;

    always_comb
    begin
        o_indexed = 1'b0;
        if (i_access_bit)
        begin
            o_addr = {i_bank_select_register, i_file_addr};
        end
        else if (i_ext_enable && (i_file_addr <= INDEXED_LIMIT))
        begin
            o_indexed = 1'b1;
            o_addr    = 12'(i_index_base + {4'h0, i_file_addr});
        end
        else if (i_file_addr < ACCESS_SPLIT)
        begin
            o_addr = {ACCESS_LOW_BANK, i_file_addr};
        end
        else
        begin
            o_addr = {ACCESS_HIGH_BANK, i_file_addr};
        end
    end
endmodule : set_file_addr_resolve
`default_nettype wire

// [core/set_file_all_ones.sv]
// Execution unit that fills an addressed data register with all ones over four phases: decode, read, process, write.
// Behaviour
// - Opcode 0110 100a ffff ffff writes FFh into the addressed data register.
// - Access bit zero resolves the file address inside the fixed access bank.
// - Access bit one combines bank select register with file address.
// - Access zero, extended set on, address at most 5Fh: indexed literal offset.
`timescale 1ns/1ps
`default_nettype none
module set_file_all_ones
    import set_file_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_instr_valid,
    input  wire logic [15:0]            i_instr_word,
    input  wire logic [3:0]             i_bank_select_register,
    input  wire logic                   i_ext_enable,
    input  wire logic [11:0]            i_index_base,
    input  wire logic [7:0]             i_read_data,
    output logic                        o_busy,
    output set_file_pkg::mem_access_type o_read,
    output set_file_pkg::mem_access_type o_write,
    output logic                        o_indexed,
    output logic                        o_status_write,
    output logic                        o_done
);
    import set_file_pkg::*;

    // ------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------
    phase_type   phase;
    phase_type   next_phase;
    logic        active;
    logic [15:0] word;
    target_type  target;
    logic        res_indexed;
    logic [11:0] res_addr;
    logic        match;

    assign match = i_instr_word[OPCODE_MSB:OPCODE_LSB] == SET_FILE_OPCODE;

    always_comb
    begin
        next_phase = phase;
        case (phase)
            PHASE_DECODE:  next_phase = active ? PHASE_READ : PHASE_DECODE;
            PHASE_READ:    next_phase = PHASE_PROCESS;
            PHASE_PROCESS: next_phase = PHASE_WRITE;
            PHASE_WRITE:   next_phase = PHASE_DECODE;
            default:       next_phase = PHASE_DECODE;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            phase <= PHASE_DECODE;
        else
            phase <= next_phase;
    end

    // The instruction is latched only while idle, so a new word cannot disturb one in flight.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            active <= 1'b0;
            word   <= RESET_WORD;
        end
        else if (phase == PHASE_DECODE && !active)
        begin
            active <= i_instr_valid && match;
            word   <= i_instr_word;
        end
        else if (phase == PHASE_WRITE)
        begin
            active <= 1'b0;
        end
    end

    set_file_addr_resolve set_file_addr_resolve_inst
    (
        .i_access_bit           (word[ACCESS_BIT_POS]),
        .i_file_addr            (word[7:0]),
        .i_bank_select_register (i_bank_select_register),
        .i_ext_enable           (i_ext_enable),
        .i_index_base           (i_index_base),
        .o_indexed              (res_indexed),
        .o_addr                 (res_addr)
    );

    // Operands are resolved at decode; later changes of bank select do not move the target.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            target <= '{valid: 1'b0, indexed: 1'b0, addr: RESET_ADDR};
        else if (phase == PHASE_DECODE && active)
            target <= '{valid: 1'b1, indexed: res_indexed, addr: res_addr};
        else if (phase == PHASE_WRITE)
            target.valid <= 1'b0;
    end

    // ------------------------------------------------------------
    // Data memory strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_read  <= '{valid: 1'b0, addr: RESET_ADDR, data: 8'h00};
            o_write <= '{valid: 1'b0, addr: RESET_ADDR, data: 8'h00};
            o_done  <= 1'b0;
        end
        else
        begin
            o_read.valid  <= next_phase == PHASE_READ;
            o_read.addr   <= (next_phase == PHASE_READ) ? res_addr : o_read.addr;
            o_read.data   <= (phase == PHASE_READ) ? i_read_data : o_read.data;
            o_write.valid <= (next_phase == PHASE_WRITE) && target.valid;
            o_write.addr  <= (next_phase == PHASE_WRITE) ? target.addr : o_write.addr;
            o_write.data  <= SET_FILE_VALUE;
            o_done        <= (next_phase == PHASE_WRITE) && target.valid;
        end
    end

    assign o_busy         = active;
    assign o_indexed      = target.indexed;
    assign o_status_write = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_write_value;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_write.valid |-> o_write.data == SET_FILE_VALUE;
    endproperty
    a_write_value: assert property (p_write_value) else $error("write not all ones");

    property p_one_cycle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(o_read.valid) |-> ##2 o_write.valid ##1 !o_write.valid;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("phase order broken");

    property p_match_starts;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (phase == PHASE_DECODE && !active && i_instr_valid && match) |-> ##2 o_read.valid;
    endproperty
    a_match_starts: assert property (p_match_starts) else $error("match not run");

    property p_nomatch_idle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (phase == PHASE_DECODE && !active && !(i_instr_valid && match)) |=> !active;
    endproperty
    a_nomatch_idle: assert property (p_nomatch_idle) else $error("bad start");

    property p_banked;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (phase == PHASE_DECODE && active && word[ACCESS_BIT_POS])
            |=> target.addr == {$past(i_bank_select_register), $past(word[7:0])};
    endproperty
    a_banked: assert property (p_banked) else $error("bank address wrong");

    property p_access;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (phase == PHASE_DECODE && active && !word[ACCESS_BIT_POS]
            && !(i_ext_enable && word[7:0] <= INDEXED_LIMIT))
            |=> target.addr == {($past(word[7]) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK),
                                $past(word[7:0])} && !target.indexed;
    endproperty
    a_access: assert property (p_access) else $error("access bank wrong");

    property p_indexed;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (phase == PHASE_DECODE && active && !word[ACCESS_BIT_POS] && i_ext_enable
            && word[7:0] <= INDEXED_LIMIT)
            |=> target.indexed && target.addr == 12'($past(i_index_base) + $past(word[7:0]));
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed mode missed");

    property p_no_status;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_write.valid |-> !o_status_write;
    endproperty
    a_no_status: assert property (p_no_status) else $error("status altered");

    property p_read_addr;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_read.valid |-> o_read.addr == target.addr;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("read addr off");

    property p_write_addr;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_write.valid |-> o_write.addr == o_read.addr;
    endproperty
    a_write_addr: assert property (p_write_addr) else $error("write addr moved");

    property p_done_pair;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_done == o_write.valid;
    endproperty
    a_done_pair: assert property (p_done_pair) else $error("done unpaired");

    // Busy must cover exactly the four phases, so the next word is taken one edge later.
    property p_busy_span;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(o_busy) |-> o_busy [*4] ##1 !o_busy;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");

    property p_read_capture;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $fell(o_read.valid) |-> o_read.data == $past(i_read_data);
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read data lost");

    property p_idle_quiet;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !o_busy |-> !o_read.valid && !o_write.valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("strobe while idle");

endmodule : set_file_all_ones
`default_nettype wire

// [testbench/set_file_all_ones_tb.sv]
// Self-checking testbench for the set-file-all-ones execution unit.
`timescale 1ns/1ps
`default_nettype none
module set_file_all_ones_tb;
    import set_file_pkg::*;
    logic           i_ref_clk;
    logic           i_sys_rst;
    logic           i_instr_valid;
    logic [15:0]    i_instr_word;
    logic [3:0]     i_bank_select_register;
    logic           i_ext_enable;
    logic [11:0]    i_index_base;
    logic [7:0]     i_read_data;
    logic           o_busy;
    mem_access_type o_read;
    mem_access_type o_write;
    logic           o_indexed;
    logic           o_status_write;
    logic           o_done;
    int             fail_count = 0;
    int             num_checks = 0;

    set_file_all_ones set_file_all_ones_inst (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
        .i_instr_word(i_instr_word), .i_bank_select_register(i_bank_select_register),
        .i_ext_enable(i_ext_enable), .i_index_base(i_index_base), .i_read_data(i_read_data),
        .o_busy(o_busy), .o_read(o_read), .o_write(o_write), .o_indexed(o_indexed),
        .o_status_write(o_status_write), .o_done(o_done));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------
    // Reporting and comparison
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic check_flag(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check_flag

    task automatic check_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check_val

    // ------------------------------------------------------------
    // Shared drivers
    // ------------------------------------------------------------
    // Polls at most eight edges, so a missing pulse ends the run instead of hanging it.
    task automatic wait_for(input bit wr, output int n);
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end while (n < 8 && (wr ? o_write.valid : o_read.valid) !== 1'b1);
        if (n == 8)
        begin
            fail_count++;
            $display("[FAIL] pulse expected 1 seen none");
            results();
        end
    endtask : wait_for

    task automatic check_quiet(input string name);
        repeat (6)
        begin
            @(posedge i_ref_clk);
            #1;
            check_flag(name, 1'b0, o_read.valid | o_write.valid);
        end
    endtask : check_quiet

    // With hold set, a second word stays offered while busy and must not be taken.
    task automatic run_op(input string name, input logic acc, input logic [7:0] f,
                          input logic [3:0] bank_select_register, input logic ext, input logic [11:0] exp_addr,
                          input logic exp_idx, input bit hold);
        int nr;
        int nw;
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b1;
        i_instr_word <= {SET_FILE_OPCODE, acc, f};
        i_bank_select_register <= bank_select_register;
        i_ext_enable <= ext;
        i_read_data <= ~f;
        @(posedge i_ref_clk);
        i_instr_valid <= hold;
        i_instr_word <= {SET_FILE_OPCODE, acc, ~f};
        #1;
        check_flag("busy", 1'b1, o_busy);
        wait_for(1'b0, nr);
        check_val("read addr", exp_addr, o_read.addr);
        wait_for(1'b1, nw);
        check_val("read to write", 12'd2, 12'(nw));
        check_val("take to write", 12'd3, 12'(nr + nw));
        check_val("read data", {4'h0, ~f}, {4'h0, o_read.data});
        check_val("write addr", exp_addr, o_write.addr);
        check_val("write data", {4'h0, SET_FILE_VALUE}, {4'h0, o_write.data});
        check_flag("done", 1'b1, o_done);
        check_flag("indexed", exp_idx, o_indexed);
        check_flag("status", 1'b0, o_status_write);
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        #1;
        check_flag("pulse end", 1'b0, o_write.valid | o_done);
        $display("test %s done", name);
    endtask : run_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_banked();
        run_op("banked", 1'b1, 8'h12, 4'h5, 1'b0, 12'h512, 1'b0, 1'b0);
    endtask : t_banked
    task automatic t_access_low();
        run_op("access low", 1'b0, 8'h7f, 4'h9, 1'b0, 12'h07f, 1'b0, 1'b0);
    endtask : t_access_low
    task automatic t_access_high();
        run_op("access high", 1'b0, 8'h80, 4'h3, 1'b1, 12'hf80, 1'b0, 1'b0);
    endtask : t_access_high
    task automatic t_indexed();
        @(posedge i_ref_clk);
        i_index_base <= 12'h7a0;
        run_op("indexed", 1'b0, 8'h5f, 4'h2, 1'b1, 12'h7ff, 1'b1, 1'b0);
    endtask : t_indexed
    task automatic t_above_limit();
        run_op("above limit", 1'b0, 8'h60, 4'h2, 1'b1, 12'h060, 1'b0, 1'b0);
    endtask : t_above_limit
    task automatic t_ext_banked();
        run_op("ext banked", 1'b1, 8'h10, 4'ha, 1'b1, 12'ha10, 1'b0, 1'b0);
    endtask : t_ext_banked
    task automatic t_foreign();
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b1;
        i_instr_word <= 16'h6a12;
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        check_quiet("foreign word");
        $display("test foreign done");
    endtask : t_foreign
    task automatic t_busy();
        run_op("busy", 1'b1, 8'h01, 4'h1, 1'b0, 12'h101, 1'b0, 1'b1);
        check_quiet("while busy");
    endtask : t_busy
    // Reset lands while a read strobe is out; everything must clear and stay quiet.
    task automatic t_mid_reset();
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b1;
        i_instr_word <= {SET_FILE_OPCODE, 1'b1, 8'h22};
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        @(posedge i_ref_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        #1;
        check_flag("mid reset", 1'b0, o_busy | o_read.valid | o_write.valid | o_done | o_indexed);
        check_quiet("after reset");
        $display("test mid reset done");
    endtask : t_mid_reset

    initial
    begin
        i_sys_rst = 1'b1;
        i_instr_valid = 1'b0;
        i_instr_word = 16'h0000;
        i_bank_select_register = 4'h0;
        i_ext_enable = 1'b0;
        i_index_base = 12'h300;
        i_read_data = 8'h00;
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        #1;
        check_flag("reset", 1'b0, o_busy | o_read.valid | o_write.valid | o_done);
        t_banked();
        t_access_low();
        t_access_high();
        t_indexed();
        t_above_limit();
        t_ext_banked();
        t_mid_reset();
        t_foreign();
        t_busy();
        results();
    end
endmodule : set_file_all_ones_tb
`default_nettype wire
